/* rtl/ccp_pwm_control.sv */
// Mode and output control for the enhanced and second capture units
//
// Function
// RULE_01: Mode zero disables the unit and returns it to reset state.
// RULE_02: Enhanced codes 0001 and 0011 do nothing.
// RULE_03: Capture edge: falling, rising, every 4th or 16th rising.
// RULE_04: Enhanced mode 0010 toggles output on match and sets flag.
// RULE_05: Modes 1000/1001 set/clear output on match and set flag.
// RULE_06: Mode 1010 only sets the flag; pin left alone.
// RULE_07: Mode 1011 sets flag and resets the first timer.
// RULE_08: Codes 11xx are PWM with per-pair output polarity.
// RULE_09: Outside PWM, steering ignored; A is unit pin, B-D port pins.
// RULE_10: Single drives A; forward modulates D; reverse modulates B.
// RULE_11: Half bridge modulates A/B complementary; C/D to port use.
// RULE_12: Bits 5-4 are duty LSBs in PWM only.
// RULE_13: Capture/compare use first timer; PWM uses second timer.
// RULE_14: Second unit matches enhanced unit minus bridge steering. The code also drives its PWM pin active-high for every 11xx code.
// RULE_15: Second control bits 7-6 read zero; 5-4 are its duty LSBs.
// RULE_16: Second unit code 0010 is reserved.
// RULE_17: Capture copies first timer and sets flag; overwrites old.
// RULE_18: Prescaler clears off capture mode, not on divisor change.
// RULE_19: Second unit 1011 also starts conversion if converter enabled.
// RULE_20: Mode 1110 gives A/C active-low, B/D active-high.
// RULE_21: Control writes act from the next clock cycle.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ccp_pwm_control
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Time bases and datapath levels
  input  wire logic [15:0] first_timer_value,
  input  wire logic        compare_match_enh,
  input  wire logic        compare_match_sec,
  input  wire logic        pwm_level_enh,
  input  wire logic        pwm_level_sec,
  input  wire logic        adc_enabled,
  // Capture pins
  input  wire logic        capture_pin_enh,
  input  wire logic        capture_pin_sec,
  // Enhanced unit pins
  output logic             bridge_out_a,
  output logic             bridge_out_b,
  output logic             bridge_out_c,
  output logic             bridge_out_d,
  output logic             bridge_oe_a_n,
  output logic             bridge_oe_b_n,
  output logic             bridge_oe_c_n,
  output logic             bridge_oe_d_n,
  // Second unit pin
  output logic             second_out,
  output logic             second_oe_n,
  // Flags, triggers and duty values
  output logic             enhanced_unit_flag,
  output logic             second_unit_flag,
  output logic             timer_reset_pulse,
  output logic             adc_start_pulse,
  output logic [9:0]       enhanced_duty,
  output logic [9:0]       second_duty,
  output logic             enhanced_uses_period_timebase,
  output logic             second_uses_period_timebase
);
  import ccp_ctrl_pkg::*;

  // Software state
  logic [7:0]  enh_ctrl_r;
  logic [7:0]  sec_ctrl_r;
  logic [7:0]  enh_duty_r;
  logic [7:0]  sec_duty_r;
  logic        enh_flag_r;
  logic        sec_flag_r;
  logic [15:0] enh_capt_r;
  logic [15:0] sec_capt_r;
  logic [31:0] prdata_r;

  // Unit state
  logic        enh_latch_r;
  logic        sec_latch_r;
  logic        sec_out_r;
  logic        sec_oe_n_r;
  logic        timer_reset_r;
  logic        adc_start_r;
  logic [9:0]  enh_duty_out_r;
  logic [9:0]  sec_duty_out_r;
  logic        enh_tb_r;
  logic        sec_tb_r;

  // Decode
  logic [3:0]  enh_mode;
  logic [3:0]  sec_mode;
  logic        enh_cap_evt;
  logic        sec_cap_evt;
  logic        enh_cmp_hit;
  logic        sec_cmp_hit;
  logic        enh_set;
  logic        sec_set;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe_n;

  assign enh_mode = enh_ctrl_r[MODE_LSB +: 4];
  assign sec_mode = sec_ctrl_r[MODE_LSB +: 4];

  // Reserved codes match no group and do nothing
  assign enh_cmp_hit = compare_match_enh && is_compare(enh_mode, 1'b1); // RULE_02
  assign sec_cmp_hit = compare_match_sec && is_compare(sec_mode, 1'b0); // RULE_16

  // Flag sources: capture events and compare matches
  assign enh_set = enh_cap_evt | enh_cmp_hit; // RULE_04 RULE_05 RULE_06
  assign sec_set = sec_cap_evt | sec_cmp_hit; // RULE_14

  // APB: zero wait states, error on unmapped address
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = prdata_r;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = READ_ZERO;
    unique case (paddr)
      OFS_ENH_CTRL: rd_mux[7:0]  = enh_ctrl_r;
      OFS_SEC_CTRL: rd_mux[7:0]  = sec_ctrl_r & SEC_CTRL_MASK; // RULE_15
      OFS_ENH_DUTY: rd_mux[7:0]  = enh_duty_r;
      OFS_SEC_DUTY: rd_mux[7:0]  = sec_duty_r;
      OFS_STATUS: begin
        rd_mux[FLAG_ENH] = enh_flag_r;
        rd_mux[FLAG_SEC] = sec_flag_r;
      end
      OFS_ENH_CAPT: rd_mux[15:0] = enh_capt_r;
      OFS_SEC_CAPT: rd_mux[15:0] = sec_capt_r;
      default:      addr_ok      = 1'b0;
    endcase
  end

  // Read data is caught in the setup cycle so it stands in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= READ_ZERO;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  // Control and duty registers; new values decode from next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_ctrl_r <= CTRL_RESET;
      sec_ctrl_r <= CTRL_RESET;
      enh_duty_r <= DUTY_RESET;
      sec_duty_r <= DUTY_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_ENH_CTRL) begin
        enh_ctrl_r <= pwdata[7:0]; // RULE_21
      end
      if (paddr == OFS_SEC_CTRL) begin
        sec_ctrl_r <= pwdata[7:0] & SEC_CTRL_MASK; // RULE_15
      end
      if (paddr == OFS_ENH_DUTY) begin
        enh_duty_r <= pwdata[7:0];
      end
      if (paddr == OFS_SEC_DUTY) begin
        sec_duty_r <= pwdata[7:0];
      end
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_flag_r <= 1'b0;
      sec_flag_r <= 1'b0;
    end else begin
      if (enh_set) begin
        enh_flag_r <= 1'b1; // RULE_17
      end else if (wr_en && paddr == OFS_STATUS && pwdata[FLAG_ENH]) begin
        enh_flag_r <= 1'b0;
      end
      if (sec_set) begin
        sec_flag_r <= 1'b1; // RULE_17
      end else if (wr_en && paddr == OFS_STATUS && pwdata[FLAG_SEC]) begin
        sec_flag_r <= 1'b0;
      end
    end
  end

  // Capture event sources, one per unit
  capture_event_gen u_cap_enh (
    .pclk     (pclk),
    .presetn  (presetn),
    .cap_en   (is_capture(enh_mode)),
    .edge_sel (enh_mode[1:0]),
    .pin_raw  (capture_pin_enh),
    .cap_evt  (enh_cap_evt)
  );

  capture_event_gen u_cap_sec (
    .pclk     (pclk),
    .presetn  (presetn),
    .cap_en   (is_capture(sec_mode)),
    .edge_sel (sec_mode[1:0]),
    .pin_raw  (capture_pin_sec),
    .cap_evt  (sec_cap_evt)
  );

  // Capture registers take the first timer; unread values are lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_capt_r <= CAPT_RESET;
      sec_capt_r <= CAPT_RESET;
    end else begin
      if (enh_cap_evt) begin
        enh_capt_r <= first_timer_value; // RULE_17 RULE_13
      end
      if (sec_cap_evt) begin
        sec_capt_r <= first_timer_value; // RULE_17
      end
    end
  end

  // Compare output latches; off mode forces the default low level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_latch_r <= 1'b0;
    end else if (enh_mode == MODE_OFF) begin
      enh_latch_r <= 1'b0; // RULE_01
    end else if (compare_match_enh) begin
      if (enh_mode == MODE_CMP_SET) begin
        enh_latch_r <= 1'b1; // RULE_05
      end else if (enh_mode == MODE_CMP_CLR) begin
        enh_latch_r <= 1'b0; // RULE_05
      end else if (enh_mode == MODE_TOGGLE) begin
        enh_latch_r <= ~enh_latch_r; // RULE_04
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_latch_r <= 1'b0;
    end else if (sec_mode == MODE_OFF) begin
      sec_latch_r <= 1'b0; // RULE_01
    end else if (compare_match_sec) begin
      if (sec_mode == MODE_CMP_SET) begin
        sec_latch_r <= 1'b1; // RULE_05
      end else if (sec_mode == MODE_CMP_CLR) begin
        sec_latch_r <= 1'b0; // RULE_05
      end
    end
  end

  // Enhanced unit pins: steering only matters in PWM
  bridge_steer u_steer (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (enh_mode),
    .steer     (enh_ctrl_r[STEER_LSB +: 2]),
    .pwm_level (pwm_level_enh),
    .cmp_latch (enh_latch_r),
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n)
  );

  assign bridge_out_a  = pin_out[0];
  assign bridge_out_b  = pin_out[1];
  assign bridge_out_c  = pin_out[2];
  assign bridge_out_d  = pin_out[3];
  assign bridge_oe_a_n = pin_oe_n[0];
  assign bridge_oe_b_n = pin_oe_n[1];
  assign bridge_oe_c_n = pin_oe_n[2];
  assign bridge_oe_d_n = pin_oe_n[3];

  // Second pin: no polarity or steering, single active-high PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_out_r  <= 1'b0;
      sec_oe_n_r <= 1'b1;
    end else if (is_pwm(sec_mode)) begin
      sec_out_r  <= pwm_level_sec; // RULE_14
      sec_oe_n_r <= 1'b0;
    end else if (sec_mode == MODE_CMP_SET || sec_mode == MODE_CMP_CLR) begin
      sec_out_r  <= sec_latch_r; // RULE_05
      sec_oe_n_r <= 1'b0;
    end else begin
      sec_out_r  <= 1'b0; // RULE_06 RULE_19
      sec_oe_n_r <= 1'b1;
    end
  end

  assign second_out  = sec_out_r;
  assign second_oe_n = sec_oe_n_r;

  // Special event: one-cycle timer reset, conversion start on second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reset_r <= 1'b0;
      adc_start_r   <= 1'b0;
    end else begin
      timer_reset_r <= (compare_match_enh && enh_mode == MODE_SPECIAL)
                       || (compare_match_sec && sec_mode == MODE_SPECIAL); // RULE_07 RULE_19
      adc_start_r   <= compare_match_sec && sec_mode == MODE_SPECIAL
                       && adc_enabled; // RULE_19
    end
  end

  assign timer_reset_pulse = timer_reset_r;
  assign adc_start_pulse   = adc_start_r;

  // Ten-bit duty only in PWM, else zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enh_duty_out_r <= 10'h000;
      sec_duty_out_r <= 10'h000;
      enh_tb_r       <= 1'b0;
      sec_tb_r       <= 1'b0;
    end else begin
      enh_duty_out_r <= is_pwm(enh_mode)
                        ? {enh_duty_r, enh_ctrl_r[DUTY_LSB +: 2]}
                        : 10'h000; // RULE_12
      sec_duty_out_r <= is_pwm(sec_mode)
                        ? {sec_duty_r, sec_ctrl_r[DUTY_LSB +: 2]}
                        : 10'h000; // RULE_15
      enh_tb_r       <= is_pwm(enh_mode); // RULE_13
      sec_tb_r       <= is_pwm(sec_mode); // RULE_13
    end
  end

  assign enhanced_duty                 = enh_duty_out_r;
  assign second_duty                   = sec_duty_out_r;
  assign enhanced_uses_period_timebase = enh_tb_r;
  assign second_uses_period_timebase   = sec_tb_r;
  assign enhanced_unit_flag            = enh_flag_r;
  assign second_unit_flag              = sec_flag_r;
endmodule

/* rtl/ccp_ctrl_pkg.sv */
// Constants and decode helpers shared by the capture/compare/PWM control
package ccp_ctrl_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_ENH_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEC_CTRL = 8'h04;
  localparam logic [7:0] OFS_ENH_DUTY = 8'h08;
  localparam logic [7:0] OFS_SEC_DUTY = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_ENH_CAPT = 8'h14;
  localparam logic [7:0] OFS_SEC_CAPT = 8'h18;

  // Reset values and write masks
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  DUTY_RESET     = 8'h00;
  localparam logic [15:0] CAPT_RESET     = 16'h0000;
  localparam logic [7:0]  SEC_CTRL_MASK  = 8'h3F;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // Control register fields
  localparam int MODE_LSB  = 0;
  localparam int DUTY_LSB  = 4;
  localparam int STEER_LSB = 6;
  localparam int FLAG_ENH  = 0;
  localparam int FLAG_SEC  = 1;

  // Mode select codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] GRP_CAPTURE  = 2'h1;
  localparam logic [1:0] GRP_COMPARE  = 2'h2;
  localparam logic [1:0] GRP_PWM      = 2'h3;

  // Capture edge choices
  localparam logic [1:0] CAP_FALL  = 2'h0;
  localparam logic [1:0] CAP_RISE  = 2'h1;
  localparam logic [1:0] CAP_DIV4  = 2'h2;
  localparam logic [1:0] CAP_DIV16 = 2'h3;
  localparam logic [3:0] CNT_LAST4  = 4'h3;
  localparam logic [3:0] CNT_LAST16 = 4'hF;

  // Output steering codes
  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD    = 2'h1;
  localparam logic [1:0] STEER_HALF   = 2'h2;
  localparam logic [1:0] STEER_REV    = 2'h3;

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == GRP_PWM;
  endfunction

  function automatic logic is_capture(input logic [3:0] m);
    return m[3:2] == GRP_CAPTURE;
  endfunction

  // Toggle compare exists only in the enhanced unit
  function automatic logic is_compare(input logic [3:0] m,
                                      input logic       enh);
    return (m[3:2] == GRP_COMPARE) || (enh && m == MODE_TOGGLE);
  endfunction
endpackage

/* rtl/capture_event_gen.sv */
// Capture pin synchroniser, edge select and prescaler
`timescale 1ns/1ps
module capture_event_gen
  import ccp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       cap_en,
  input  wire logic [1:0] edge_sel,
  // Pin and event
  input  wire logic       pin_raw,
  output logic            cap_evt
);
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [3:0] count_r;
  logic       rise;
  logic       fall;
  logic       evt_nxt;

  // Two stages before any logic sees the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // Counter cleared only off capture; changing divisor keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 4'h0;
    end else if (!cap_en) begin
      count_r <= 4'h0; // RULE_18
    end else if (rise) begin
      count_r <= count_r + 4'h1;
    end
  end

  // Edge choice per capture setting
  always_comb begin
    unique case (edge_sel)
      CAP_FALL:  evt_nxt = fall;
      CAP_RISE:  evt_nxt = rise;
      CAP_DIV4:  evt_nxt = rise && count_r[1:0] == CNT_LAST4[1:0];
      CAP_DIV16: evt_nxt = rise && count_r == CNT_LAST16;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_evt <= 1'b0;
    end else begin
      cap_evt <= cap_en & evt_nxt; // RULE_03
    end
  end
endmodule

/* rtl/bridge_steer.sv */
// Enhanced unit output steering and polarity for the four bridge pins
`timescale 1ns/1ps
module bridge_steer
  import ccp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [3:0] mode,
  input  wire logic [1:0] steer,
  input  wire logic       pwm_level,
  input  wire logic       cmp_latch,
  // Pins a..d in bits 0..3
  output logic [3:0]      pin_out,
  output logic [3:0]      pin_oe_n
);
  logic [3:0] out_nxt;
  logic [3:0] oe_n_nxt;
  logic       pol_ac;
  logic       pol_bd;
  logic       cmp_drive;

  // Mode bit 1 inverts A/C, bit 0 inverts B/D
  assign pol_ac = mode[1]; // RULE_08 RULE_20
  assign pol_bd = mode[0]; // RULE_08
  assign cmp_drive = (mode == MODE_TOGGLE) || (mode == MODE_CMP_SET)
                     || (mode == MODE_CMP_CLR);

  // Pins not driven are released to port use
  always_comb begin
    out_nxt  = 4'h0;
    oe_n_nxt = 4'hF;
    if (is_pwm(mode)) begin
      unique case (steer)
        STEER_SINGLE: begin
          out_nxt[0]  = pwm_level ^ pol_ac; // RULE_10
          oe_n_nxt    = 4'hE;
        end
        STEER_FWD: begin
          out_nxt  = {pwm_level ^ pol_bd, pol_ac, pol_bd, ~pol_ac}; // RULE_10
          oe_n_nxt = 4'h0;
        end
        STEER_HALF: begin
          out_nxt[0] = pwm_level ^ pol_ac; // RULE_11
          out_nxt[1] = ~pwm_level ^ pol_bd; // RULE_11
          oe_n_nxt   = 4'hC;
        end
        STEER_REV: begin
          out_nxt  = {pol_bd, ~pol_ac, pwm_level ^ pol_bd, pol_ac}; // RULE_10
          oe_n_nxt = 4'h0;
        end
      endcase
    end else if (cmp_drive) begin
      out_nxt[0]  = cmp_latch; // RULE_09
      oe_n_nxt[0] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 4'h0;
      pin_oe_n <= 4'hF;
    end else begin
      pin_out  <= out_nxt;
      pin_oe_n <= oe_n_nxt;
    end
  end
endmodule

/* tb/ccp_pwm_control_sva.sv */
// Port checker for the capture/compare/PWM control block
`timescale 1ns/1ps
module ccp_pwm_control_sva
  import ccp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Datapath inputs
  input wire logic        compare_match_enh,
  input wire logic        compare_match_sec,
  input wire logic        adc_enabled,
  // Watched outputs
  input wire logic        bridge_out_a,
  input wire logic        bridge_oe_a_n,
  input wire logic        bridge_oe_d_n,
  input wire logic        enhanced_unit_flag,
  input wire logic        timer_reset_pulse,
  input wire logic        adc_start_pulse,
  input wire logic [9:0]  enhanced_duty
);
  logic [7:0] enh_r, sec_r;
  logic       wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow control registers, same write edge
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {enh_r, sec_r} <= 16'h0000;
    else if (wr && paddr == OFS_ENH_CTRL) enh_r <= pwdata[7:0];
    else if (wr && paddr == OFS_SEC_CTRL) sec_r <= pwdata[7:0];
  end
  // Pins follow the mode one edge later
  a_off_release: assert property (
    enh_r[3:0] == MODE_OFF |=> bridge_oe_a_n && bridge_oe_d_n)
    else $error("pin driven while off");
  a_cmp_flag: assert property (
    compare_match_enh && enh_r[3:2] == GRP_COMPARE |=> enhanced_unit_flag)
    else $error("no flag on match");
  a_set_pin: assert property (
    compare_match_enh && enh_r[3:0] == MODE_CMP_SET
    ##1 enh_r[3:0] == MODE_CMP_SET |=> bridge_out_a && !bridge_oe_a_n)
    else $error("pin not set on match");
  a_timer_reset: assert property (
    compare_match_enh && enh_r[3:0] == MODE_SPECIAL |=> timer_reset_pulse)
    else $error("no timer reset");
  a_adc_start: assert property (
    compare_match_sec && sec_r[3:0] == MODE_SPECIAL && adc_enabled
    |=> adc_start_pulse)
    else $error("no conversion start");
  a_fwd_steer: assert property (
    enh_r == 8'h4C |=> bridge_out_a && !bridge_oe_a_n && !bridge_oe_d_n)
    else $error("forward drive wrong");
  a_steer_ignored: assert property (
    enh_r[3:2] != GRP_PWM |=> bridge_oe_d_n)
    else $error("pin d driven outside pwm");
  a_duty_off: assert property (
    !is_pwm(enh_r[3:0]) |=> enhanced_duty == 10'h000)
    else $error("duty nonzero outside pwm");
  a_duty_lsb: assert property (
    is_pwm(enh_r[3:0]) ##1 $stable(enh_r)
    |-> enhanced_duty[1:0] == enh_r[5:4])
    else $error("duty low bits wrong");
  c_toggle: cover property (compare_match_enh && enh_r[3:0] == MODE_TOGGLE);
  c_trst: cover property (timer_reset_pulse);
  c_adc: cover property (adc_start_pulse);
endmodule

bind ccp_pwm_control ccp_pwm_control_sva ccp_pwm_control_sva_i (.*);

/* tb/pin_load_model.sv */
// Board side: capture edge source and pulled-down bridge loads
`timescale 1ns/1ps
module pin_load_model (
  // Clock
  input wire logic       pclk,
  // Bridge pins from the block
  input wire logic [3:0] out_pins,
  input wire logic [3:0] oe_n_pins,
  // Levels seen on the board
  output logic [3:0]     pad_level,
  output logic           cap_enh,
  output logic           cap_sec
);
  // Released pads read the pull-down level
  assign pad_level = out_pins & ~oe_n_pins;
  initial {cap_enh, cap_sec} = 2'b00;
  // Slow pulses the synchroniser cannot miss
  task automatic pulse(input bit sec, input int n);
    repeat (n) begin
      @(posedge pclk);
      {cap_sec, cap_enh} <= sec ? 2'b10 : 2'b01;
      repeat (4) @(posedge pclk);
      {cap_sec, cap_enh} <= 2'b00;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

/* tb/capture_compare_pwm_control_test.sv */
// Self-checking bench for the capture/compare/PWM control block
`timescale 1ns/1ps
module capture_compare_pwm_control_test;
  import ccp_ctrl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        cm_e, cm_s, lv_e, lv_s, adc_en, cap_e, cap_s, s_out, s_oe_n;
  logic        f_e, f_s, trst, adcs, tb_e, tb_s;
  logic [15:0] tval;
  logic [3:0]  bo, bz_n, pad;
  logic [9:0]  duty_e, duty_s;
  int          errors = 0, total_checks = 0, trst_cnt = 0, adc_cnt = 0;

  // Block under test and its board
  ccp_pwm_control ccp_pwm_control_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .first_timer_value(tval),
    .compare_match_enh(cm_e), .compare_match_sec(cm_s),
    .pwm_level_enh(lv_e), .pwm_level_sec(lv_s), .adc_enabled(adc_en),
    .capture_pin_enh(cap_e), .capture_pin_sec(cap_s),
    .bridge_out_a(bo[0]), .bridge_out_b(bo[1]), .bridge_out_c(bo[2]),
    .bridge_out_d(bo[3]), .bridge_oe_a_n(bz_n[0]),
    .bridge_oe_b_n(bz_n[1]), .bridge_oe_c_n(bz_n[2]),
    .bridge_oe_d_n(bz_n[3]), .second_out(s_out), .second_oe_n(s_oe_n),
    .enhanced_unit_flag(f_e), .second_unit_flag(f_s),
    .timer_reset_pulse(trst), .adc_start_pulse(adcs),
    .enhanced_duty(duty_e), .second_duty(duty_s),
    .enhanced_uses_period_timebase(tb_e),
    .second_uses_period_timebase(tb_s));
  pin_load_model pin_load_model_i (.pclk, .out_pins(bo),
    .oe_n_pins(bz_n), .pad_level(pad), .cap_enh(cap_e), .cap_sec(cap_s));

  // Clock and pulse counters
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (trst === 1'b1) trst_cnt++;
    if (adcs === 1'b1) adc_cnt++;
  end

  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [16:0] r);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report;
    end
    r = {pslverr, prdata[15:0]};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [16:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [16:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r[15:0], exp);
  endtask

  task automatic match(input bit sec);
    @(posedge pclk);
    {cm_s, cm_e} <= sec ? 2'b10 : 2'b01;
    @(posedge pclk);
    {cm_s, cm_e} <= 2'b00;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_regs;
    logic [16:0] r;
    rdc(OFS_ENH_CTRL, 16'h0000);
    rdc(OFS_SEC_CTRL, 16'h0000);
    wr(OFS_SEC_CTRL, 8'hFF);
    rdc(OFS_SEC_CTRL, 16'h003F);
    wr(OFS_ENH_CTRL, 8'hFF);
    rdc(OFS_ENH_CTRL, 16'h00FF);
    apb(1'b0, 8'h1C, 8'h00, r);
    chk(r[16:1], 16'h8000);
  endtask

  // Compare modes of both units: {flag, oe_n or trigger, pad}
  task automatic t_compare;
    logic [3:0] m [10] = '{1, 2, 3, 8, 9, 10, 11, 2, 11, 8};
    logic [2:0] e [10] = '{2, 5, 2, 5, 4, 6, 6, 0, 6, 5};
    int t0;
    adc_en <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      wr(i < 7 ? OFS_ENH_CTRL : OFS_SEC_CTRL, 8'h00);
      wr(OFS_STATUS, 8'h03);
      wr(i < 7 ? OFS_ENH_CTRL : OFS_SEC_CTRL, {4'h0, m[i]});
      t0 = (i < 7) ? trst_cnt : adc_cnt;
      match(i >= 7);
      if (i < 7) chk(16'({f_e, bz_n[0], pad[0]}), 16'(e[i]));
      else chk(16'({f_s, adc_cnt != t0, s_out & ~s_oe_n}), 16'(e[i]));
      if (i < 7) chk(16'(trst_cnt - t0), 16'(m[i] == MODE_SPECIAL));
    end
    wr(OFS_SEC_CTRL, 8'h00);
    repeat (3) @(posedge pclk);
    chk(16'(s_oe_n), 16'h0001);
  endtask

  function automatic logic [7:0] steer_exp(input logic [1:0] s, p,
                                           input logic l);
    logic [3:0] o, z;
    case (s)
      STEER_SINGLE: begin o = {3'b000, l ^ p[1]}; z = 4'b1110; end
      STEER_FWD: begin o = {l ^ p[0], p[1], p[0], ~p[1]}; z = 4'b0000; end
      STEER_HALF: begin o = {2'b00, ~l ^ p[0], l ^ p[1]}; z = 4'b1100; end
      default: begin o = {p[0], ~p[1], l ^ p[0], p[1]}; z = 4'b0000; end
    endcase
    return {z, o & ~z};
  endfunction

  // All steering, polarity and level codes
  task automatic t_pwm;
    for (int k = 0; k < 32; k++) begin
      lv_e <= k[0];
      wr(OFS_ENH_CTRL, {k[4:3], 4'b0011, k[2:1]});
      repeat (3) @(posedge pclk);
      chk(16'({bz_n, pad}), 16'(steer_exp(k[4:3], k[2:1], k[0])));
    end
  endtask

  task automatic t_duty;
    lv_s <= 1'b1;
    wr(OFS_ENH_DUTY, 8'hA5);
    wr(OFS_SEC_DUTY, 8'h5A);
    wr(OFS_ENH_CTRL, 8'hEC);
    wr(OFS_SEC_CTRL, 8'h1C);
    repeat (3) @(posedge pclk);
    chk(16'({tb_e, duty_e}), 16'h0696);
    chk(16'({s_out, s_oe_n, tb_s, duty_s}), 16'h1569);
    wr(OFS_ENH_CTRL, 8'h68);
    repeat (3) @(posedge pclk);
    chk(16'({tb_e, bz_n[3:1], duty_e}), 16'h1C00);
  endtask

  // Capture edge choices, then a divisor change mid-count
  task automatic t_capture;
    int n [4] = '{1, 1, 4, 16};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_ENH_CTRL, 8'h00);
      wr(OFS_STATUS, 8'h03);
      wr(OFS_ENH_CTRL, i < 4 ? 8'(4 + i) : 8'h06);
      tval <= 16'h1230 + 16'(i);
      if (i == 4) pin_load_model_i.pulse(0, 2);
      if (i == 4) wr(OFS_ENH_CTRL, 8'h07);
      pin_load_model_i.pulse(0, i < 4 ? n[i] - 1 : 13);
      repeat (6) @(posedge pclk);
      chk(16'(f_e), 16'h0000);
      pin_load_model_i.pulse(0, 1);
      repeat (6) @(posedge pclk);
      chk(16'(f_e), 16'h0001);
      rdc(OFS_ENH_CAPT, 16'h1230 + 16'(i));
    end
    wr(OFS_STATUS, 8'h03);
    wr(OFS_SEC_CTRL, 8'h05);
    pin_load_model_i.pulse(1, 1);
    repeat (6) @(posedge pclk);
    chk(16'(f_s), 16'h0001);
    rdc(OFS_SEC_CAPT, 16'h1234);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report;
  end

  initial begin
    {presetn, psel, penable, pwrite, cm_e, cm_s, lv_e, lv_s} = 8'h00;
    {paddr, pwdata, adc_en, tval} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_compare;
    t_pwm;
    t_duty;
    t_capture;
    final_report;
  end
endmodule
